// ---- rtl/slf_line_framer.sv ----
// Purpose: S/T frame coder, mode straps, activation and loop-back 2
// Assumes: U-side symbols and serial-bus codes arrive on the system clock
// Notes:   straps, receive data and activity pass a two-stage synchroniser
`timescale 1ns/100ps
`default_nettype none
module slf_line_framer (
  input  wire logic             clock_in,
  input  wire logic             rst_in,
  input  wire logic             frame_sync_in,
  input  wire slf_pkg::slf_ci_t ci_cmd_in,
  input  wire slf_pkg::slf_sym_t u_sym_in,
  input  wire logic [6:0]       u_sym_pos_in,
  input  wire logic             u_sym_valid_in,
  input  wire logic             u_data_tx_in,
  input  wire logic             u_deact_in,
  input  wire logic             channel_select_pin_in,
  input  wire logic             aux_bus_strap_a_n_in,
  input  wire logic             aux_bus_strap_b_n_in,
  input  wire logic             sm_toggle_in,
  input  wire logic             line_activity_in,
  input  wire logic             info3_in,
  input  wire logic             info0_in,
  input  wire logic             rx_line_in,
  input  wire logic             dn_data_in,
  input  wire logic             s_bit_in,
  output logic                  data_req_out,
  output slf_pkg::slf_ci_t      u_ci_out,
  output slf_pkg::slf_ci_t      s_ci_out,
  output logic                  loop_closed_out,
  output logic                  channel_out,
  output logic                  lt_mode_out,
  output logic                  pulse_p_out,
  output logic                  pulse_n_out,
  output logic                  up_bit_out,
  output logic                  up_valid_out,
  output logic [2:0]            dac_phase_out,
  output logic                  dac_tail_out
);
  import slf_pkg::*;

  logic       bit_tick;
  logic       step_tick;
  slf_ci_if   ci ();

  slf_rate #(.INC(LINE_BPS / 1000), .MOD(CLK_HZ / 1000)) u_bit_rate (
    .clock_in (clock_in),
    .rst_in   (rst_in),
    .tick_out (bit_tick)
  );
  slf_rate #(.INC(STEP_HZ / 1000), .MOD(CLK_HZ / 1000)) u_step_rate (
    .clock_in (clock_in),
    .rst_in   (rst_in),
    .tick_out (step_tick)
  );

  assign ci.raw   = ci_cmd_in;
  assign ci.frame = frame_sync_in;
  slf_dll u_dll (
    .clock_in (clock_in),
    .rst_in   (rst_in),
    .ci       (ci)
  );

  // pin synchroniser: ics, strap a, strap b, rx line, activity
  logic [4:0] sy1_q;
  logic [4:0] sy2_q;
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      sy1_q <= 5'h06;
      sy2_q <= 5'h06;
    end else begin
      sy1_q <= {line_activity_in, rx_line_in, aux_bus_strap_b_n_in,
                aux_bus_strap_a_n_in, channel_select_pin_in};
      sy2_q <= sy1_q;
    end
  end
  logic ics_s;
  logic sel_en;
  logic rx_s;
  logic act_s;
  assign ics_s  = sy2_q[0];
  assign sel_en = ~sy2_q[1] & ~sy2_q[2];
  assign rx_s   = sy2_q[3];
  assign act_s  = sy2_q[4];

  // mode selection
  logic tog_q;
  logic tog_d;
  always_comb begin
    tog_d = tog_q;
    if (sm_toggle_in && sel_en) begin
      tog_d = ~tog_q;
    end
  end
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      tog_q <= 1'b0;
    end else begin
      tog_q <= tog_d;
    end
  end
  assign channel_out = sel_en & ~ics_s;
  assign lt_mode_out = sel_en & (~ics_s ^ tog_q);

  // maintenance-channel loop commands
  logic [3:0] plus_run_q;
  logic [3:0] plus_run_d;
  logic [3:0] zero_run_q;
  logic [3:0] zero_run_d;
  logic       loop_q;
  logic       loop_d;
  logic       m_take;
  slf_ci_t    u_ci_q;
  slf_ci_t    u_ci_d;
  assign m_take = u_sym_valid_in && (u_sym_pos_in == M_POS);

  always_comb begin
    plus_run_d = plus_run_q;
    zero_run_d = zero_run_q;
    loop_d     = loop_q;
    if (m_take) begin
      plus_run_d = (u_sym_in == SYM_PLUS) ? plus_run_q + 4'h1 : 4'h0;
      zero_run_d = (u_sym_in == SYM_ZERO) ? zero_run_q + 4'h1 : 4'h0;
      if (plus_run_d == 4'(RUN_LEN)) begin
        loop_d     = 1'b1;
        plus_run_d = 4'(RUN_LEN - 1);
      end
      if (zero_run_d == 4'(RUN_LEN)) begin
        loop_d     = 1'b0;
        zero_run_d = 4'(RUN_LEN - 1);
      end
    end
    if (u_deact_in) begin
      loop_d = 1'b0;
    end
    if (loop_q) begin
      u_ci_d = u_data_tx_in ? CI_LOOP_IND : CI_LOOP_REQ;
    end else begin
      u_ci_d = u_data_tx_in ? CI_AI : CI_ACT_REQ;
    end
  end
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      plus_run_q <= 4'h0;
      zero_run_q <= 4'h0;
      loop_q     <= 1'b0;
      u_ci_q     <= CI_ACT_REQ;
    end else begin
      plus_run_q <= plus_run_d;
      zero_run_q <= zero_run_d;
      loop_q     <= loop_d;
      u_ci_q     <= u_ci_d;
    end
  end
  assign loop_closed_out = loop_q;
  assign u_ci_out        = u_ci_q;

  // activation state machine
  slf_state_t st_q;
  slf_state_t st_d;
  slf_ci_t    s_ci_d;
  slf_ci_t    s_ci_q;
  logic       cmd_act_grp;
  logic       cmd_ind_grp;
  logic       s_loop;
  assign cmd_act_grp = (ci.code == CI_ACT_REQ) || (ci.code == CI_LOOP_REQ);
  assign cmd_ind_grp = (ci.code == CI_AI) || (ci.code == CI_LOOP_IND);
  assign s_loop      = (ci.code == CI_LOOP_REQ) || (ci.code == CI_LOOP_IND);

  always_comb begin
    st_d   = st_q;
    s_ci_d = CI_DI;
    unique case (st_q)
      ST_DEACT: begin
        s_ci_d = act_s ? CI_TIM : CI_DI;
        if (act_s) begin
          st_d = ST_DET;
        end
      end
      ST_DET: begin
        s_ci_d = CI_ACT_REQ;
        if (cmd_act_grp || lt_mode_out) begin
          st_d = ST_PEND;
        end
      end
      ST_PEND: begin
        s_ci_d = CI_ACT_REQ;
        if (info3_in && (cmd_ind_grp || lt_mode_out)) begin
          st_d = ST_ACT;
        end
      end
      ST_ACT: begin
        s_ci_d = CI_AI;
        if (info0_in) begin
          st_d = ST_PEND;
        end
      end
      ST_PDEACT: begin
        s_ci_d = CI_DI;
        if (ci.code == CI_DC) begin
          st_d = ST_DEACT;
        end
      end
      default: st_d = ST_DEACT;
    endcase
    if (ci.code == CI_DEACT_REQ && st_q != ST_DEACT && st_q != ST_PDEACT) begin
      st_d = ST_PDEACT;
    end
    if (ci.code == CI_RES) begin
      st_d = ST_DEACT;
    end
  end
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      st_q   <= ST_DEACT;
      s_ci_q <= CI_DI;
    end else begin
      st_q   <= st_d;
      s_ci_q <= s_ci_d;
    end
  end
  assign s_ci_out = s_ci_q;

  // frame layout toward the terminals
  function automatic slf_bit_t bit_type(input logic [5:0] p);
    slf_bit_t t;
    t = BT_B;
    unique case (p)
      6'd0:                         t = BT_F;
      6'd1, 6'd47:                  t = BT_L;
      6'd10, 6'd23, 6'd34, 6'd45:   t = BT_E;
      6'd11, 6'd24, 6'd35, 6'd46:   t = BT_D;
      6'd12:                        t = BT_A;
      6'd13:                        t = BT_FA;
      6'd14:                        t = BT_N;
      6'd25:                        t = BT_M;
      6'd36:                        t = BT_S;
      default:                      t = BT_B;
    endcase
    return t;
  endfunction

  logic [5:0] pos_q;
  logic [5:0] pos_d;
  logic [5:0] rx_pos_q;
  logic [5:0] rx_pos_d;
  logic [4:0] mf_q;
  logic [4:0] mf_d;
  logic       par_q;
  logic       par_d;
  logic       last_q;
  logic       last_d;
  logic       viol_q;
  logic       viol_d;
  logic       echo_q;
  logic       echo_d;
  logic [1:0] dly_q;
  logic [1:0] dly_d;
  logic       pp_d;
  logic       pn_d;
  logic       ub_d;
  logic       uv_d;
  logic       v;
  logic       pol;
  logic       tx_on;
  logic       rx_data;
  slf_bit_t   bt;
  slf_bit_t   rbt;
  assign bt      = bit_type(pos_q);
  assign rbt     = bit_type(rx_pos_q);
  assign rx_data = (rbt == BT_B) || (rbt == BT_D);
  assign tx_on   = (st_q == ST_PEND) || (st_q == ST_ACT);
  assign data_req_out = bit_tick && ((bt == BT_B) || (bt == BT_D));

  always_comb begin
    pos_d    = pos_q;
    rx_pos_d = rx_pos_q;
    mf_d     = mf_q;
    par_d    = par_q;
    last_d   = last_q;
    viol_d   = viol_q;
    echo_d   = echo_q;
    dly_d    = dly_q;
    pp_d     = pulse_p_out;
    pn_d     = pulse_n_out;
    ub_d     = up_bit_out;
    uv_d     = 1'b0;
    pol      = ~last_q;
    unique case (bt)
      BT_F:    v = 1'b0;
      BT_L:    v = ~par_q;
      BT_E:    v = echo_q;
      BT_A:    v = (st_q == ST_ACT);
      BT_FA:   v = (mf_q == 5'h00);
      BT_N:    v = (mf_q != 5'h00);
      BT_M:    v = (mf_q == 5'h00);
      BT_S:    v = s_bit_in;
      default: v = dn_data_in;
    endcase
    if (bit_tick) begin
      pos_d    = (pos_q == POS_LAST) ? POS_RST : pos_q + 6'h01;
      rx_pos_d = (rx_pos_q == POS_LAST) ? POS_RST : rx_pos_q + 6'h01;
      if (pos_q == POS_LAST) begin
        mf_d = (mf_q == MF_LAST) ? 5'h00 : mf_q + 5'h01;
      end
      if (bt == BT_F) begin
        pol = 1'b1;
      end else if (viol_q) begin
        pol = last_q;
      end
      if (bt == BT_L) begin
        par_d  = 1'b0;
        viol_d = (pos_q == 6'd1);
      end else if (!v) begin
        par_d = ~par_q;
      end
      if (!v) begin
        last_d = pol;
        if (bt != BT_L) begin
          viol_d = 1'b0;
        end
      end
      pp_d  = tx_on && !v && pol;
      pn_d  = tx_on && !v && !pol;
      dly_d = {dly_q[0], v};
      if (bt == BT_E) begin
        echo_d = 1'b1;
      end
      if (rbt == BT_D) begin
        echo_d = echo_d & rx_s;
      end
      if (rx_data) begin
        ub_d = s_loop ? dly_q[1] : rx_s;
        uv_d = 1'b1;
      end
    end
  end
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      pos_q        <= POS_RST;
      rx_pos_q     <= RX_POS_RST;
      mf_q         <= 5'h00;
      par_q        <= 1'b0;
      last_q       <= 1'b0;
      viol_q       <= 1'b0;
      echo_q       <= 1'b1;
      dly_q        <= 2'h3;
      pulse_p_out  <= 1'b0;
      pulse_n_out  <= 1'b0;
      up_bit_out   <= 1'b1;
      up_valid_out <= 1'b0;
    end else begin
      pos_q        <= pos_d;
      rx_pos_q     <= rx_pos_d;
      mf_q         <= mf_d;
      par_q        <= par_d;
      last_q       <= last_d;
      viol_q       <= viol_d;
      echo_q       <= echo_d;
      dly_q        <= dly_d;
      pulse_p_out  <= pp_d;
      pulse_n_out  <= pn_d;
      up_bit_out   <= ub_d;
      up_valid_out <= uv_d;
    end
  end

  // transmit pulse sequencer: phase 0..2 overlaps the previous pulse tail
  logic [2:0] ph_q;
  logic [2:0] ph_d;
  logic       tail_q;
  logic       tail_d;
  always_comb begin
    ph_d   = ph_q;
    tail_d = tail_q;
    if (step_tick) begin
      ph_d   = ph_q + 3'h1;
      tail_d = (ph_d < 3'(PULSE_OVLP)) && (ph_q != 3'h0 || tail_q || ph_d == 3'h0);
    end
  end
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      ph_q   <= 3'h0;
      tail_q <= 1'b0;
    end else begin
      ph_q   <= ph_d;
      tail_q <= tail_d;
    end
  end
  assign dac_phase_out = ph_q;
  assign dac_tail_out  = tail_q;

  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);

  loop_close_a: assert property (m_take && u_sym_in == SYM_PLUS && !u_deact_in
    && plus_run_q == 4'(RUN_LEN - 1) |=> loop_q)
    else $error("loop not closed after plus run");
  loop_open_a: assert property (m_take && u_sym_in == SYM_ZERO
    && zero_run_q == 4'(RUN_LEN - 1) |=> !loop_q)
    else $error("loop not opened after zero run");
  deact_open_a: assert property (u_deact_in |=> !loop_q)
    else $error("loop stays closed at deactivation");
  loop_hold_a: assert property (loop_q && !u_deact_in && !m_take |=> loop_q)
    else $error("loop opened without cause");
  ci_code_a: assert property (##1 u_ci_out == ($past(loop_q)
    ? ($past(u_data_tx_in) ? CI_LOOP_IND : CI_LOOP_REQ)
    : ($past(u_data_tx_in) ? CI_AI : CI_ACT_REQ)))
    else $error("wrong upstream loop code");
  frame_pos_a: assert property (bit_tick && bt == BT_F && tx_on
    |=> pulse_p_out && !pulse_n_out)
    else $error("framing bit not positive");
  one_nopulse_a: assert property (bit_tick && v |=> !pulse_p_out && !pulse_n_out)
    else $error("pulse sent for binary one");
  balance_bit_a: assert property (bit_tick && bt == BT_L |-> v == !par_q)
    else $error("balance bit parity wrong");
  code_viol_a: assert property (bit_tick && !v && viol_q && bt != BT_F && tx_on
    |=> (pulse_p_out == $past(last_q)))
    else $error("violation polarity wrong");
  rx_offset_a: assert property (6'((32'(rx_pos_q) + RX_OFFSET) % FRAME_BITS) == pos_q)
    else $error("upstream offset lost");
  fixed_nt_a: assert property (!sel_en |-> !lt_mode_out && !channel_out)
    else $error("mode selected with straps high");
  tail_a: assert property (dac_tail_out |-> dac_phase_out < 3'(PULSE_OVLP))
    else $error("pulse overlap too long");

  loop_seen_c: cover property (!loop_q ##1 loop_q);
  active_c:    cover property (st_q == ST_PEND ##1 st_q == ST_ACT);
  viol_c:      cover property (bit_tick && viol_q && !v && tx_on);
endmodule
`default_nettype wire

// ---- rtl/slf_pkg.sv ----
// Purpose: shared constants and types of the S/T line framer with loop-back
// Assumes: 25 MHz system clock
// Notes:   line and step rates are produced by phase accumulators
package slf_pkg;
  localparam int unsigned CLK_HZ       = 25000000;
  localparam int unsigned LINE_BPS     = 192000;
  localparam int unsigned USER_BPS     = 144000;
  localparam int unsigned OVHD_BPS     = 48000;
  localparam int unsigned STEP_PER_MS  = 960;
  localparam int unsigned STEP_HZ      = STEP_PER_MS * 1000;
  localparam int unsigned FRAME_BITS   = 48;
  localparam int unsigned RX_OFFSET    = 2;
  localparam int unsigned MF_FRAMES    = 20;
  localparam int unsigned RUN_LEN      = 8;
  localparam int unsigned PULSE_STEPS  = 11;
  localparam int unsigned PULSE_PERIOD = 8;
  localparam int unsigned PULSE_OVLP   = PULSE_STEPS - PULSE_PERIOD;
  localparam logic [6:0]  M_POS        = 7'h55;
  localparam logic [5:0]  POS_RST      = 6'h00;
  localparam logic [5:0]  RX_POS_RST   = 6'(FRAME_BITS - RX_OFFSET);
  localparam logic [5:0]  POS_LAST     = 6'(FRAME_BITS - 1);
  localparam logic [4:0]  MF_LAST      = 5'(MF_FRAMES - 1);

  typedef logic [3:0] slf_ci_t;
  // serial-bus control and indication codes
  localparam slf_ci_t CI_DEACT_REQ = 4'h0;
  localparam slf_ci_t CI_TIM       = 4'h0;
  localparam slf_ci_t CI_RES       = 4'h1;
  localparam slf_ci_t CI_ACT_REQ   = 4'h8;
  localparam slf_ci_t CI_LOOP_REQ  = 4'hA;
  localparam slf_ci_t CI_AI        = 4'hC;
  localparam slf_ci_t CI_LOOP_IND  = 4'hE;
  localparam slf_ci_t CI_DC        = 4'hF;
  localparam slf_ci_t CI_DI        = 4'hF;
  localparam slf_ci_t CI_RST       = 4'hF;

  typedef logic [1:0] slf_sym_t;
  localparam slf_sym_t SYM_ZERO  = 2'h0;
  localparam slf_sym_t SYM_PLUS  = 2'h1;
  localparam slf_sym_t SYM_MINUS = 2'h2;

  typedef enum logic [2:0] {
    ST_DEACT  = 3'b000,
    ST_DET    = 3'b001,
    ST_PEND   = 3'b010,
    ST_ACT    = 3'b011,
    ST_PDEACT = 3'b100
  } slf_state_t;

  typedef enum logic [3:0] {
    BT_F  = 4'b0000,
    BT_L  = 4'b0001,
    BT_B  = 4'b0010,
    BT_D  = 4'b0011,
    BT_E  = 4'b0100,
    BT_A  = 4'b0101,
    BT_FA = 4'b0110,
    BT_N  = 4'b0111,
    BT_M  = 4'b1000,
    BT_S  = 4'b1001
  } slf_bit_t;
endpackage

// ---- rtl/slf_ci_if.sv ----
// Purpose: carries a serial-bus code and its frame strobe to the filter
// Assumes: all signals on the system clock
// Notes:   valid code changes only after the filter has confirmed it
`timescale 1ns/100ps
`default_nettype none
interface slf_ci_if;
  import slf_pkg::*;
  slf_ci_t raw;
  logic    frame;
  slf_ci_t code;
  modport filt (input raw, input frame, output code);
  modport user (output raw, output frame, input code);
endinterface
`default_nettype wire

// ---- rtl/slf_rate.sv ----
// Purpose: one-cycle enable at an exact average rate
// Assumes: INC below MOD
// Notes:   phase accumulator, jitter of one clock
`timescale 1ns/100ps
`default_nettype none
module slf_rate #(
  parameter int unsigned INC = 1,
  parameter int unsigned MOD = 2
) (
  input  wire logic clock_in,
  input  wire logic rst_in,
  output logic      tick_out
);
  import slf_pkg::*;
  logic [31:0] acc_q;
  logic [31:0] acc_d;
  logic        tick_d;

  always_comb begin
    tick_d = 1'b0;
    acc_d  = acc_q + INC;
    if (acc_q >= MOD - INC) begin
      acc_d  = acc_q + INC - MOD;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      acc_q    <= '0;
      tick_out <= 1'b0;
    end else begin
      acc_q    <= acc_d;
      tick_out <= tick_d;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/slf_dll.sv ----
// Purpose: two-frame confirmation of an incoming serial-bus code
// Assumes: frame strobe is one cycle per serial-bus frame
// Notes:   code reads CI_RST until a code is confirmed
`timescale 1ns/100ps
`default_nettype none
module slf_dll (
  input wire logic clock_in,
  input wire logic rst_in,
  slf_ci_if.filt   ci
);
  import slf_pkg::*;
  slf_ci_t last_q;
  slf_ci_t last_d;
  slf_ci_t code_q;
  slf_ci_t code_d;

  always_comb begin
    last_d = last_q;
    code_d = code_q;
    if (ci.frame) begin
      last_d = ci.raw;
      if (ci.raw == last_q) begin
        code_d = ci.raw;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      last_q <= CI_RST;
      code_q <= CI_RST;
    end else begin
      last_q <= last_d;
      code_q <= code_d;
    end
  end

  assign ci.code = code_q;

  confirm_two_a: assert property (@(posedge clock_in) disable iff (rst_in)
    (code_q != $past(code_q)) |-> ($past(ci.frame) && $past(ci.raw) == $past(last_q)))
    else $error("code changed without two equal frames");
endmodule
`default_nettype wire

// ---- dv/slf_te_model.sv ----
// Purpose: terminal-side stand-in on the S/T bus
// Assumes: system clock, receiver detections as levels
// Notes:   sends idle ones, answers received pulses with INFO3
`timescale 1ns/100ps
`default_nettype none
module slf_te_model (
  input  wire logic clock_in,
  input  wire logic rst_in,
  input  wire logic wake_in,
  input  wire logic pulse_p_in,
  input  wire logic pulse_n_in,
  output logic      line_activity_out,
  output logic      info3_out,
  output logic      info0_out,
  output logic      rx_line_out,
  output logic      err_out
);
  logic seen_q;
  logic seen_d;
  logic err_q;
  logic err_d;
  always_comb begin
    seen_d = wake_in & (seen_q | pulse_p_in | pulse_n_in);
    err_d  = err_q | (pulse_p_in & pulse_n_in);
  end
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      seen_q <= 1'b0;
      err_q  <= 1'b0;
    end else begin
      seen_q <= seen_d;
      err_q  <= err_d;
    end
  end
  assign line_activity_out = wake_in;
  assign info3_out         = seen_q;
  assign info0_out         = ~wake_in;
  assign rx_line_out       = 1'b1;
  assign err_out           = err_q;
endmodule
`default_nettype wire

// ---- dv/slf_line_framer_tb.sv ----
// Purpose: self-checking bench for the S/T line framer
// Assumes: 25 MHz clock, terminal model on the S/T side
// Notes:   loop rows first, then straps, activation and line checks
`timescale 1ns/100ps
`default_nettype none
module slf_line_framer_tb;
  import slf_pkg::*;
  typedef struct {
    slf_sym_t   sym;
    logic [6:0] pos;
    int         n;
    logic       tx;
    logic       loop;
    slf_ci_t    ci;
  } slf_row_t;
  logic       clock_in = 1'b0;
  logic       rst_in = 1'b1;
  logic       fsync = 1'b0;
  slf_ci_t    ci_cmd = CI_DC;
  slf_sym_t   sym = SYM_ZERO;
  logic [6:0] pos = 7'h00;
  logic       sym_v = 1'b0;
  logic       u_tx = 1'b0;
  logic       u_deact = 1'b0;
  logic       cs = 1'b1;
  logic       sa = 1'b0;
  logic       sb = 1'b0;
  logic       tog = 1'b0;
  logic       wake = 1'b0;
  logic       dn = 1'b1;
  logic       data_req, loop, chan, lt, pp, pn, upb, upv, act, i3, i0, rx, te_err;
  slf_ci_t    u_ci, s_ci;
  int         failures = 0, check_count = 0;
  int         np = 0, nn = 0, nd = 0, nv = 0, n1 = 0, nw = 0, nt = 0;
  int         p0, n0, d0, v0, u0, w0, t0;
  logic [2:0] dph, dph_q = 3'h0;
  logic       dtl, dtl_q = 1'b0;
  slf_row_t   rows [10];

  slf_line_framer i_dut (.clock_in(clock_in), .rst_in(rst_in), .frame_sync_in(fsync),
    .ci_cmd_in(ci_cmd), .u_sym_in(sym), .u_sym_pos_in(pos), .u_sym_valid_in(sym_v),
    .u_data_tx_in(u_tx), .u_deact_in(u_deact), .channel_select_pin_in(cs),
    .aux_bus_strap_a_n_in(sa), .aux_bus_strap_b_n_in(sb), .sm_toggle_in(tog),
    .line_activity_in(act), .info3_in(i3), .info0_in(i0), .rx_line_in(rx),
    .dn_data_in(dn), .s_bit_in(1'b0), .data_req_out(data_req), .u_ci_out(u_ci),
    .s_ci_out(s_ci), .loop_closed_out(loop), .channel_out(chan), .lt_mode_out(lt),
    .pulse_p_out(pp), .pulse_n_out(pn), .up_bit_out(upb), .up_valid_out(upv),
    .dac_phase_out(dph), .dac_tail_out(dtl));
  slf_te_model i_te (.clock_in(clock_in), .rst_in(rst_in), .wake_in(wake),
    .pulse_p_in(pp), .pulse_n_in(pn), .line_activity_out(act), .info3_out(i3),
    .info0_out(i0), .rx_line_out(rx), .err_out(te_err));

  always #20 clock_in = ~clock_in;
  always @(posedge clock_in) begin
    if (pp === 1'b1) np <= np + 1;
    if (pn === 1'b1) nn <= nn + 1;
    if (data_req === 1'b1) nd <= nd + 1;
    if (upv === 1'b1) nv <= nv + 1;
    if (upv === 1'b1 && upb === 1'b1) n1 <= n1 + 1;
    dph_q <= dph;
    dtl_q <= dtl;
    if (dph_q === 3'h7 && dph === 3'h0) nw <= nw + 1;
    if (dtl_q === 1'b0 && dtl === 1'b1) nt <= nt + 1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
  endtask
  task automatic check_val(input string nm, input logic [3:0] e, input logic [3:0] g);
    #1;
    check_count++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic check_int(input string nm, input int e, input int g, input int tol);
    check_count++;
    if (g < e - tol || g > e + tol) begin
      failures++;
      $display("Error %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic send_sym(input slf_sym_t s, input logic [6:0] p, input int n);
    @(posedge clock_in);
    sym   <= s;
    pos   <= p;
    sym_v <= 1'b1;
    tick(n);
    sym_v <= 1'b0;
  endtask
  task automatic send_ci(input slf_ci_t c, input int n);
    @(posedge clock_in);
    ci_cmd <= c;
    repeat (n) begin
      tick(8);
      fsync <= 1'b1;
      @(posedge clock_in);
      fsync <= 1'b0;
    end
    tick(8);
  endtask
  task automatic conclude();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    tick(80000);
    failures++;
    conclude();
  end

  initial begin
    rows = '{'{SYM_PLUS, M_POS, 7, 1'b0, 1'b0, CI_ACT_REQ},
             '{SYM_MINUS, M_POS, 1, 1'b0, 1'b0, CI_ACT_REQ},
             '{SYM_PLUS, M_POS, 7, 1'b0, 1'b0, CI_ACT_REQ},
             '{SYM_PLUS, M_POS, 1, 1'b0, 1'b1, CI_LOOP_REQ},
             '{SYM_MINUS, M_POS, 4, 1'b1, 1'b1, CI_LOOP_IND},
             '{SYM_ZERO, M_POS, 7, 1'b1, 1'b1, CI_LOOP_IND},
             '{SYM_ZERO, 7'h54, 8, 1'b1, 1'b1, CI_LOOP_IND},
             '{SYM_ZERO, M_POS, 1, 1'b1, 1'b0, CI_AI},
             '{SYM_PLUS, 7'h56, 8, 1'b0, 1'b0, CI_ACT_REQ},
             '{SYM_PLUS, M_POS, 8, 1'b0, 1'b1, CI_LOOP_REQ}};
    tick(7);
    check_val("reset loop", 4'h0, 4'(loop));
    check_val("reset u_ci", CI_ACT_REQ, u_ci);
    check_val("reset s_ci", CI_DI, s_ci);
    check_val("reset pulses", 4'h0, 4'({pp, pn}));
    @(posedge clock_in);
    rst_in <= 1'b0;
    tick(4);
    foreach (rows[i]) begin
      u_tx <= rows[i].tx;
      send_sym(rows[i].sym, rows[i].pos, rows[i].n);
      tick(3);
      check_val("loop", 4'(rows[i].loop), 4'(loop));
      check_val("u_ci", rows[i].ci, u_ci);
    end
    u_deact <= 1'b1;
    tick(2);
    u_deact <= 1'b0;
    tick(3);
    check_val("loop on deact", 4'h0, 4'(loop));
    send_sym(SYM_PLUS, M_POS, 8);
    tick(2);
    rst_in <= 1'b1;
    tick(3);
    rst_in <= 1'b0;
    tick(3);
    check_val("loop after reset", 4'h0, 4'(loop));
    for (int i = 7; i >= 0; i--) begin
      {sa, sb, cs} <= 3'(i);
      tick(5);
      check_val("lt_mode", 4'(i == 0), 4'(lt));
      check_val("channel", 4'(i == 0), 4'(chan));
    end
    cs <= 1'b1;
    tick(5);
    for (int j = 0; j < 2; j++) begin
      tog <= 1'b1;
      @(posedge clock_in);
      tog <= 1'b0;
      tick(4);
      check_val("lt toggle", 4'(j == 0), 4'(lt));
    end
    wake <= 1'b1;
    tick(10);
    check_val("s_ci detect", CI_ACT_REQ, s_ci);
    send_ci(CI_ACT_REQ, 1);
    p0 = np + nn;
    tick(7000);
    check_int("pulses one frame", 0, np + nn - p0, 0);
    send_ci(CI_ACT_REQ, 2);
    p0 = np + nn;
    tick(7000);
    check_val("pulses pending", 4'h1, 4'(np + nn > p0));
    send_ci(CI_AI, 2);
    tick(50);
    check_val("s_ci active", CI_AI, s_ci);
    {d0, p0, n0, v0} = {nd, np, nn, nv};
    {w0, t0} = {nw, nt};
    tick(25000);
    check_int("pulse starts", 120, nw - w0, 1);
    check_int("pulse tails", 120, nt - t0, 1);
    check_int("data bits", 144, nd - d0, 1);
    check_int("upstream bits", 144, nv - v0, 1);
    check_int("balance", np - p0, nn - n0, 400);
    dn <= 1'b0;
    send_ci(CI_LOOP_IND, 2);
    tick(300);
    {p0, v0, u0} = {np + nn, nv, n1};
    tick(7000);
    check_int("looped ones", 0, n1 - u0, 0);
    check_val("looped forward", 4'h1, 4'(np + nn > p0 && nv > v0));
    send_ci(CI_AI, 2);
    tick(300);
    {v0, u0} = {nv, n1};
    tick(7000);
    check_int("line ones", nv - v0, n1 - u0, 0);
    send_ci(CI_DEACT_REQ, 2);
    tick(300);
    p0 = np + nn;
    tick(7000);
    check_int("pulses deact", 0, np + nn - p0, 0);
    check_val("both polarities", 4'h0, 4'(te_err));
    conclude();
  end
endmodule
`default_nettype wire
